// file: logic/spi_eeprom_array.sv
module spi_eeprom_array #(
    parameter int PROG_TIME_NS = eeprom_pkg::PROG_TIME_NS_DEFAULT
) (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic sck,
    input  wire logic selectN,
    input  wire logic sdi,
    output logic      sdoOut,
    output logic      sdoOeN,
    input  wire logic blockProtectHigh,
    input  wire logic blockProtectLow,
    output logic      writeEnableLatch,
    output logic      writeInProgressFlag,
    output logic      statusWriteDisable
);

    // =====================================================
    // Derived constants
    localparam int PAGE_BITS = eeprom_pkg::PAGE_BYTES * 8;
    localparam int AW        = eeprom_pkg::ADDR_W;
    localparam int PL        = eeprom_pkg::PAGE_LSB;
    localparam int WL        = eeprom_pkg::WORD_LSB;
    localparam int CW        = eeprom_pkg::CODE_W;
    localparam int DW        = eeprom_pkg::DATA_W;
    // Program time rounds up to whole cycles, never below one
    localparam int PROG_RAW  = (PROG_TIME_NS + eeprom_pkg::CLK_PERIOD_NS - 1)
                               / eeprom_pkg::CLK_PERIOD_NS;
    localparam logic [19:0] PROG_CYCLES = 20'((PROG_RAW < 1) ? 1 : PROG_RAW);

    // =====================================================
    // State types
    typedef struct packed {
        logic [4:0]              hdrCnt;
        logic [7:0]              shiftIn;
        logic [7:0]              opcode;
        logic [6:0]              addrHigh;
        logic [AW-1:0]           addr;
        logic [2:0]              dataBit;
        logic                    readActive;
        logic                    writeActive;
        logic                    writeOk;
        logic                    wenOk;
        logic                    busyMeta;
        logic                    busySync;
        logic [PAGE_BITS-1:0]    pageData;
        logic [eeprom_pkg::PAGE_BYTES-1:0] pageMask;
    } link_state_t;

    typedef struct packed {
        logic                    selMeta;
        logic                    selSync;
        logic                    selPrev;
        logic [1:0]              bpMeta;
        logic [1:0]              bpSync;
        logic                    latch;
        logic                    busy;
        logic                    swd;
        eeprom_pkg::prog_state_t state;
        logic [3:0]              wordIdx;
        logic [19:0]             waitCnt;
        logic [AW-PL-1:0]        page;
        logic [PAGE_BITS-1:0]    data;
        logic [eeprom_pkg::PAGE_BYTES-1:0] mask;
    } core_state_t;

    // Select idles high, so its synchroniser resets high to avoid a false edge
    localparam core_state_t CORE_RESET = '{
        selMeta: 1'b1, selSync: 1'b1, selPrev: 1'b1,
        bpMeta: 2'h0, bpSync: 2'h0, latch: 1'b0, busy: 1'b0, swd: 1'b0,
        state: eeprom_pkg::PROG_IDLE, wordIdx: 4'h0, waitCnt: 20'h00000,
        page: '0, data: '0, mask: '0
    };

    link_state_t            lq;
    link_state_t            ld;
    core_state_t            cq;
    core_state_t            cd;
    logic                   frameArm_q;
    logic                   sdoBit_q;
    logic [7:0]             sh;
    logic [4:0]             hdr;
    logic [2:0]             bitNow;
    logic [PL-1:0]          slot;
    logic [CW-1:0]          mem [eeprom_pkg::MEM_WORDS];
    logic [CW-1:0]          rdCode;
    logic [DW-1:0]          rdData;
    logic [7:0]             readByte;
    logic                   selRise;
    logic [3:0]             wordMask;
    logic [CW-1:0]          oldCode;
    logic [DW-1:0]          oldData;
    logic [DW-1:0]          newData;
    logic                   memWe;
    logic [AW-WL-1:0]       memIdx;
    logic [CW-1:0]          memWord;

    // =====================================================
    // Link side: frame start marker
    // Set while deselected; the first rising edge of a frame clears it
    always_ff @(posedge sck or posedge selectN) begin
        if (selectN) begin
            frameArm_q <= 1'b1;
        end else begin
            frameArm_q <= 1'b0;
        end
    end

    // Array byte under the read pointer, corrected on the fly
    // Array is quasi-static here: it only changes while reads are refused
    always_comb begin
        rdCode   = mem[lq.addr[AW-1:WL]];
        rdData   = eeprom_pkg::eccCorrect(rdCode[DW-1:0], rdCode[CW-1:DW]);
        readByte = rdData[lq.addr[WL-1:0]*8 +: 8];
    end

    // Serial receive, decode and pointer logic on rising edges
    always_comb begin
        ld     = lq;
        slot   = '0;
        bitNow = '0;
        if (frameArm_q) begin
            ld.hdrCnt      = '0;
            ld.dataBit     = '0;
            ld.readActive  = 1'b0;
            ld.writeActive = 1'b0;
            ld.pageMask    = '0;
        end
        sh          = {lq.shiftIn[6:0], sdi};
        ld.shiftIn  = sh;
        ld.busyMeta = cq.busy;
        ld.busySync = lq.busyMeta;
        ld.wenOk    = 1'b0;
        ld.writeOk  = 1'b0;
        hdr         = ld.hdrCnt;
        if (hdr != eeprom_pkg::HDR_BITS) begin
            ld.hdrCnt = hdr + 5'h01;
            if (hdr == eeprom_pkg::OPC_LAST) begin
                ld.opcode = sh;
                ld.wenOk  = (sh == eeprom_pkg::OP_LATCH);
            end
            if (hdr == eeprom_pkg::ADRH_LAST) begin
                ld.addrHigh = sh[6:0];
            end
            if (hdr == eeprom_pkg::ADRL_LAST) begin
                ld.addr        = {ld.addrHigh, sh};
                ld.readActive  = (ld.opcode == eeprom_pkg::OP_READ) && !lq.busySync;
                ld.writeActive = (ld.opcode == eeprom_pkg::OP_WRITE);
            end
        end else begin
            bitNow     = ld.dataBit;
            ld.dataBit = bitNow + 3'h1;
            if (bitNow == eeprom_pkg::BYTE_LAST) begin
                if (ld.readActive) begin
                    ld.addr = ld.addr + 15'h0001;
                end
                if (ld.writeActive) begin
                    slot                    = ld.addr[PL-1:0];
                    ld.pageData[slot*8 +: 8] = sh;
                    ld.pageMask[slot]       = 1'b1;
                    ld.addr[PL-1:0]         = slot + 6'h01;
                    ld.writeOk              = 1'b1;
                end
            end
        end
    end

    // No reset here: every frame restarts from the select marker
    always_ff @(posedge sck) begin
        lq <= ld;
    end

    // Read data moves on falling edges, MSB first
    always_ff @(negedge sck) begin
        if (lq.readActive) begin
            sdoBit_q <= readByte[eeprom_pkg::BYTE_LAST - lq.dataBit];
        end else begin
            sdoBit_q <= 1'b1;
        end
    end

    // Released the instant select rises, even mid-byte
    assign sdoOut = sdoBit_q;
    assign sdoOeN = selectN | frameArm_q | !lq.readActive;

    // =====================================================
    // Core side: commit, word merge and program timer
    // Merge the page bytes for one word into its corrected old contents
    always_comb begin
        memIdx   = {cq.page, cq.wordIdx};
        wordMask = cq.mask[cq.wordIdx*eeprom_pkg::WORD_BYTES +: eeprom_pkg::WORD_BYTES];
        oldCode  = mem[memIdx];
        oldData  = eeprom_pkg::eccCorrect(oldCode[DW-1:0], oldCode[CW-1:DW]);
        for (int b = 0; b < eeprom_pkg::WORD_BYTES; b++) begin
            if (wordMask[b]) begin
                newData[b*8 +: 8] = cq.data[(cq.wordIdx*eeprom_pkg::WORD_BYTES + b)*8 +: 8];
            end else begin
                newData[b*8 +: 8] = oldData[b*8 +: 8];
            end
        end
        memWord = {eeprom_pkg::eccEncode(newData), newData};
    end

    always_comb begin
        cd         = cq;
        cd.selMeta = selectN;
        cd.selSync = cq.selMeta;
        cd.selPrev = cq.selSync;
        cd.bpMeta  = {blockProtectHigh, blockProtectLow};
        cd.bpSync  = cq.bpMeta;
        selRise    = cq.selSync && !cq.selPrev;
        memWe      = 1'b0;
        case (cq.state)
            eeprom_pkg::PROG_IDLE: begin
                // Link state is frozen once select is high: no clock edges
                if (selRise && lq.wenOk) begin
                    cd.latch = 1'b1;
                end else if (selRise && lq.writeOk && lq.writeActive && cq.latch
                             && !eeprom_pkg::isProtected(cq.bpSync,
                                                         lq.addr[AW-1:eeprom_pkg::PROT_LSB])) begin
                    cd.busy    = 1'b1;
                    cd.state   = eeprom_pkg::PROG_WORDS;
                    cd.wordIdx = '0;
                    cd.page    = lq.addr[AW-1:PL];
                    cd.data    = lq.pageData;
                    cd.mask    = lq.pageMask;
                end
            end
            eeprom_pkg::PROG_WORDS: begin
                // Only touched words are rewritten, each as a whole word
                memWe      = |wordMask;
                cd.wordIdx = cq.wordIdx + 4'h1;
                if (cq.wordIdx == eeprom_pkg::WORD_LAST) begin
                    cd.state   = eeprom_pkg::PROG_WAIT;
                    cd.waitCnt = PROG_CYCLES - 20'h00001;
                end
            end
            eeprom_pkg::PROG_WAIT: begin
                // Commits arriving now are ignored outright
                if (cq.waitCnt == '0) begin
                    cd.state = eeprom_pkg::PROG_IDLE;
                    cd.busy  = 1'b0;
                    cd.latch = 1'b0;
                end else begin
                    cd.waitCnt = cq.waitCnt - 20'h00001;
                end
            end
            default: begin
                cd.state = eeprom_pkg::PROG_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cq <= CORE_RESET;
        end else begin
            cq <= cd;
        end
    end

    // Reset restores delivery contents: every word erased with valid check bits
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            for (int w = 0; w < eeprom_pkg::MEM_WORDS; w++) begin
                mem[w] <= eeprom_pkg::ERASED_CODE;
            end
        end else if (memWe) begin
            mem[memIdx] <= memWord;
        end
    end

    assign writeEnableLatch    = cq.latch;
    assign writeInProgressFlag = cq.busy;
    assign statusWriteDisable  = cq.swd;

    // =====================================================
    // Checks
    chk_busy_covers_cycle: assert property (
        @(posedge mclk) disable iff (!rstn)
        (cq.state != eeprom_pkg::PROG_IDLE) |-> cq.busy)
        else $error("busy flag low during write cycle");

    chk_latch_cleared_end: assert property (
        @(posedge mclk) disable iff (!rstn)
        $fell(cq.busy) |-> !cq.latch)
        else $error("enable latch still set after write cycle");

    chk_start_needs_latch: assert property (
        @(posedge mclk) disable iff (!rstn)
        $rose(cq.busy) |-> $past(cq.latch) && cq.latch)
        else $error("write cycle started without enable latch");

    chk_busy_ignores_commit: assert property (
        @(posedge mclk) disable iff (!rstn)
        (cq.busy && selRise) |=> $stable(cq.page) && $stable(cq.mask))
        else $error("commit accepted during write cycle");

    chk_protect_respected: assert property (
        @(posedge mclk) disable iff (!rstn)
        $rose(cq.busy) |-> !eeprom_pkg::isProtected($past(cq.bpSync),
                                                    cq.page[AW-PL-1:AW-PL-2]))
        else $error("write cycle started in protected region");

    // Sixteen word slots, one per cycle, then the timed wait
    chk_words_then_wait: assert property (
        @(posedge mclk) disable iff (!rstn)
        $rose(cq.busy) |-> (cq.state == eeprom_pkg::PROG_WORDS)[*8]
                           ##1 (cq.state == eeprom_pkg::PROG_WORDS)[*8]
                           ##1 (cq.state == eeprom_pkg::PROG_WAIT))
        else $error("page not programmed in one pass");

    chk_code_consistent: assert property (
        @(posedge mclk) disable iff (!rstn)
        memWe |-> (eeprom_pkg::eccEncode(memWord[DW-1:0]) == memWord[CW-1:DW]))
        else $error("stored check bits do not match data");

    chk_word_keeps_old: assert property (
        @(posedge mclk) disable iff (!rstn)
        (memWe && !wordMask[0]) |-> (memWord[7:0] == oldData[7:0]))
        else $error("unwritten byte of word altered");

    chk_read_refused: assert property (
        @(posedge sck) disable iff (selectN)
        (!frameArm_q && lq.hdrCnt == eeprom_pkg::ADRL_LAST && lq.busySync) |=> !lq.readActive)
        else $error("read accepted while write cycle runs");

    chk_read_wraps: assert property (
        @(posedge sck) disable iff (selectN)
        (!frameArm_q && lq.readActive && lq.hdrCnt == eeprom_pkg::HDR_BITS
         && lq.dataBit == eeprom_pkg::BYTE_LAST && (&lq.addr)) |=> (lq.addr == '0))
        else $error("read address did not wrap to zero");

    chk_page_stays: assert property (
        @(posedge sck) disable iff (selectN)
        (!frameArm_q && lq.writeActive && lq.hdrCnt == eeprom_pkg::HDR_BITS)
        |=> (lq.addr[AW-1:PL] == $past(lq.addr[AW-1:PL])))
        else $error("write pointer left its page");

    // Commit side: a cycle starts only from a clean commit
    chk_start_on_commit: assert property (
        @(posedge mclk) disable iff (!rstn)
        $rose(cq.busy) |-> $past(selRise))
        else $error("write cycle started without select rise");

    chk_cut_write_dropped: assert property (
        @(posedge mclk) disable iff (!rstn)
        (selRise && cq.state == eeprom_pkg::PROG_IDLE && !lq.writeOk)
        |=> !cq.busy)
        else $error("write cycle started from a cut frame");

    chk_latch_from_command: assert property (
        @(posedge mclk) disable iff (!rstn)
        $rose(cq.latch) |-> $past(selRise && lq.wenOk))
        else $error("enable latch set without its command");

    chk_busy_ends_on_time: assert property (
        @(posedge mclk) disable iff (!rstn)
        (cq.state == eeprom_pkg::PROG_WAIT && cq.waitCnt == '0)
        |=> !cq.busy && (cq.state == eeprom_pkg::PROG_IDLE))
        else $error("busy flag outlived the program wait");

    // Each touched word lands in the array exactly as merged
    chk_word_lands: assert property (
        @(posedge mclk) disable iff (!rstn)
        memWe |=> (mem[$past(memIdx)] == $past(memWord)))
        else $error("merged word not stored");

    // Link side: pointer steps once per completed byte
    chk_read_steps: assert property (
        @(posedge sck) disable iff (selectN)
        (!frameArm_q && lq.readActive && lq.hdrCnt == eeprom_pkg::HDR_BITS
         && lq.dataBit == eeprom_pkg::BYTE_LAST)
        |=> (lq.addr == $past(lq.addr) + 15'h0001))
        else $error("read address did not step");

    chk_write_steps: assert property (
        @(posedge sck) disable iff (selectN)
        (!frameArm_q && lq.writeActive && lq.hdrCnt == eeprom_pkg::HDR_BITS
         && lq.dataBit == eeprom_pkg::BYTE_LAST)
        |=> (lq.addr[PL-1:0] == $past(lq.addr[PL-1:0]) + 6'h01))
        else $error("write address did not step in page");

endmodule

// file: pkg/eeprom_pkg.sv
// Function
// - Read loads address, returns byte there
// - Address bit 15 ignored on decode
// - Read increments address after each byte
// - Read address wraps to zero past top
// - Select high ends read, output released
// - Read refused while write cycle runs
// - Select rise on boundary starts write cycle
// - Page bytes programmed in one write cycle
// - Write increments low bits, wraps in page
// - Write refused without write enable latch
// - Write refused while earlier cycle runs
// - Write discarded unless select rises on boundary
// - Write refused into block protected region
// - Six check bits per word, single-bit correction
// - Any byte write reprograms whole word
// - Delivered array all ones, protect bits zero
// - Input sampled MSB first on rising edges
// - Output shifted MSB first on falling edges
// - Output high impedance while not selected
// - Both modes: rise samples, fall drives
// - Latch clear refuses every write instruction
// - Busy flag high exactly during write cycle
package eeprom_pkg;

    // =====================================================
    // Array geometry
    localparam int ADDR_W     = 15;
    localparam int MEM_BYTES  = 32768;
    localparam int WORD_BYTES = 4;
    localparam int MEM_WORDS  = MEM_BYTES / WORD_BYTES;
    localparam int PAGE_BYTES = 64;
    localparam int PAGE_WORDS = PAGE_BYTES / WORD_BYTES;
    localparam int PAGE_LSB   = 6;
    localparam int WORD_LSB   = 2;
    localparam int PROT_LSB   = 13;
    localparam int DATA_W     = 32;
    localparam int CHK_W      = 6;
    localparam int CODE_W     = DATA_W + CHK_W;

    // =====================================================
    // Instruction codes and frame positions
    localparam logic [7:0] OP_READ    = 8'h03;
    localparam logic [7:0] OP_WRITE   = 8'h02;
    localparam logic [7:0] OP_LATCH   = 8'h06;
    localparam logic [4:0] OPC_LAST   = 5'h07;
    localparam logic [4:0] ADRH_LAST  = 5'h0F;
    localparam logic [4:0] ADRL_LAST  = 5'h17;
    localparam logic [4:0] HDR_BITS   = 5'h18;
    localparam logic [2:0] BYTE_LAST  = 3'h7;
    localparam logic [3:0] WORD_LAST  = 4'hF;

    // =====================================================
    // Delivery values and protection encodings
    localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;
    localparam logic [1:0]  BP_QUARTER  = 2'h1;
    localparam logic [1:0]  BP_HALF     = 2'h2;
    localparam logic [1:0]  BP_ALL      = 2'h3;

    // =====================================================
    // Timing
    localparam int CLK_PERIOD_NS        = 8;
    localparam int PROG_TIME_NS_DEFAULT = 5000000;

    typedef enum logic [1:0] {PROG_IDLE, PROG_WORDS, PROG_WAIT} prog_state_t;

    // Hamming check bits: data fills every non-power-of-two position
    function automatic logic [5:0] eccEncode(input logic [31:0] data);
        logic [5:0] chk;
        int         k;
        chk = '0;
        k   = 0;
        for (int p = 1; p <= CODE_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (data[k]) begin
                    chk = chk ^ CHK_W'(p);
                end
                k++;
            end
        end
        return chk;
    endfunction

    // Syndrome names the flipped position; check-bit errors need no fix
    function automatic logic [31:0] eccCorrect(input logic [31:0] data,
                                               input logic [5:0]  chk);
        logic [5:0]  syn;
        logic [31:0] fixed;
        int          k;
        syn   = eccEncode(data) ^ chk;
        fixed = data;
        k     = 0;
        for (int p = 1; p <= CODE_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (CHK_W'(p) == syn) begin
                    fixed[k] = ~fixed[k];
                end
                k++;
            end
        end
        return fixed;
    endfunction

    // Protected region grows downward from the top of the array
    function automatic logic isProtected(input logic [1:0] bp, input logic [1:0] top);
        case (bp)
            BP_ALL:     return 1'b1;
            BP_HALF:    return top[1];
            BP_QUARTER: return &top;
            default:    return 1'b0;
        endcase
    endfunction

    localparam logic [CODE_W-1:0] ERASED_CODE = {eccEncode(ERASED_WORD), ERASED_WORD};

endpackage

// file: verification/spi_eeprom_array_read_write_bench.sv
module spi_eeprom_array_read_write_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================
    // Signals and model state
    localparam int PROG_NS  = 8000;
    localparam int PROG_CYC = PROG_NS / eeprom_pkg::CLK_PERIOD_NS;
    logic       mclk, rstn, sck, selectN, sdi, sdoOut, sdoOeN;
    logic       bpHigh, bpLow, latchSet, busyFlag, writeDisable;
    wire        sdoLine;
    int         failures, samples_checked, seed, busyLen, driveLen;
    logic [7:0] mem [int];
    logic [7:0] rx [$];
    int         protAddr [3] = '{32'h6000, 32'h4000, 32'h0000};

    assign sdoLine = sdoOeN ? 1'bz : sdoOut;

    spi_eeprom_array #(.PROG_TIME_NS(PROG_NS)) i_spi_eeprom_array (
        .mclk(mclk), .rstn(rstn), .sck(sck), .selectN(selectN), .sdi(sdi),
        .sdoOut(sdoOut), .sdoOeN(sdoOeN), .blockProtectHigh(bpHigh), .blockProtectLow(bpLow),
        .writeEnableLatch(latchSet), .writeInProgressFlag(busyFlag),
        .statusWriteDisable(writeDisable)
    );

    spi_master_model i_spi_master_model (
        .sck(sck), .selectN(selectN), .sdi(sdi), .sdoLine(sdoLine)
    );

    initial mclk = 1'b0;
    always #4 mclk = ~mclk;

    // Busy and drive spans, counted in core cycles
    always @(posedge mclk) begin
        if (busyFlag === 1'b1) busyLen++;
        if (sdoOeN === 1'b0) driveLen++;
    end

    // ==========================================
    // Shared tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
        samples_checked++;
        if (seen !== expv) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", what, expv, seen);
        end
    endtask

    function automatic logic [7:0] memAt(input int a);
        return mem.exists(a & 32'h7FFF) ? mem[a & 32'h7FFF] : 8'hFF;
    endfunction

    // Either clock mode at random; the device must accept both
    task automatic sendFrame(input int nbits, input logic [7:0] tx[$]);
        i_spi_master_model.cpol = 1'($random(seed));
        i_spi_master_model.frame(nbits, tx, rx);
    endtask

    task automatic setLatch();
        sendFrame(8, {eeprom_pkg::OP_LATCH});
        repeat (6) @(posedge mclk);
    endtask

    // accept: 0 refused, 1 taken, 2 refused while busy (no start check)
    task automatic doWrite(input int addr, input int n, input int extra, input int accept);
        logic [7:0] tx[$];
        logic [7:0] d;
        logic       seen;
        tx = {eeprom_pkg::OP_WRITE, 8'(addr >> 8), 8'(addr)};
        for (int i = 0; i <= n; i++) begin
            d = 8'($random(seed));
            tx.push_back(d);
            if (accept == 1 && i < n) mem[(addr & 32'h7FC0) | ((addr + i) & 32'h3F)] = d;
        end
        // A write sent into a running cycle must not restart the span count
        if (accept != 2) busyLen = 0;
        sendFrame(24 + 8 * n + extra, tx);
        seen = 1'b0;
        repeat (20) begin
            @(posedge mclk);
            seen = seen | busyFlag;
        end
        if (accept != 2) check("write started", 32'(seen), accept);
    endtask

    task automatic waitIdle();
        int n;
        n = 0;
        while (busyFlag !== 1'b0 && n < 1200) begin
            @(posedge mclk);
            n++;
        end
        @(posedge mclk);
        check("busy cleared", busyFlag, 0);
        check("busy span", 32'(busyLen >= PROG_CYC && busyLen <= PROG_CYC + 20), 1);
        check("latch cleared", latchSet, 0);
    endtask

    task automatic doRead(input int addr, input int n, input int extra, input bit refuse);
        logic [7:0] tx[$];
        tx = {eeprom_pkg::OP_READ, 8'(addr >> 8), 8'(addr)};
        for (int i = 0; i <= n; i++) tx.push_back(8'h00);
        driveLen = 0;
        sendFrame(24 + 8 * n + extra, tx);
        check("read driven", 32'(driveLen != 0), 32'(!refuse));
        check("output released", sdoOeN, 1);
        for (int i = 0; i < n && !refuse; i++) begin
            check("read byte", rx[3 + i], memAt(addr + i));
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Whole run is well under this span; a hang is cut here
    initial begin
        #600000;
        failures++;
        complete_run();
    end

    // ==========================================
    // Main sequence
    initial begin
        seed = 67;
        rstn = 1'b0;
        bpHigh = 1'b0;
        bpLow = 1'b0;
        failures = 0;
        samples_checked = 0;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        repeat (6) @(posedge mclk);
        check("write disable", writeDisable, 0);
        check("latch at start", latchSet, 0);
        check("idle output", sdoOeN, 1);
        doRead(32'hFFFE, 4, 0, 0);
        doWrite(32'h0100, 2, 0, 0);
        setLatch();
        check("latch set", latchSet, 1);
        doWrite(32'hFFFE, 66, 0, 1);
        waitIdle();
        setLatch();
        doWrite(32'h0001, 1, 0, 1);
        waitIdle();
        doRead(32'hFFF0, 20, 0, 0);
        // Second write lands while the first cycle still runs
        setLatch();
        doWrite(32'h0200, 4, 0, 1);
        doWrite(32'h0240, 2, 0, 2);
        doRead(32'h0200, 2, 0, 1);
        waitIdle();
        doRead(32'h023C, 8, 0, 0);
        setLatch();
        doWrite(32'h0300, 1, 3, 0);
        for (int b = 1; b <= 3; b++) begin
            @(posedge mclk);
            {bpHigh, bpLow} <= 2'(b);
            repeat (4) @(posedge mclk);
            setLatch();
            doWrite(protAddr[b - 1], 1, 0, 0);
        end
        @(posedge mclk);
        {bpHigh, bpLow} <= 2'h1;
        repeat (4) @(posedge mclk);
        doWrite(32'h5FFF, 1, 0, 1);
        waitIdle();
        doRead(32'h5FFC, 8, 0, 0);
        doRead(32'h0300, 2, 5, 0);
        doRead(32'h0000, 4, 0, 0);
        complete_run();
    end
endmodule

// file: verification/spi_master_model.sv
module spi_master_model (
    output logic      sck,
    output logic      selectN,
    output logic      sdi,
    input  wire logic sdoLine
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================
    // Link state
    localparam int HALF_NS = 40;
    logic cpol;

    initial begin
        cpol    = 1'b0;
        sck     = 1'b0;
        selectN = 1'b1;
        sdi     = 1'b0;
    end

    // ==========================================
    // One framed transfer; clock only runs inside the frame
    task automatic frame(input int nbits, input logic [7:0] tx[$], output logic [7:0] rx[$]);
        logic [7:0] sh;
        rx  = {};
        sh  = 8'h00;
        sck = cpol;
        #HALF_NS;
        selectN = 1'b0;
        #HALF_NS;
        for (int i = 0; i < nbits; i++) begin
            sck = 1'b0;
            sdi = tx[i / 8][7 - (i % 8)];
            #HALF_NS;
            sh  = {sh[6:0], sdoLine};
            sck = 1'b1;
            #HALF_NS;
            if (i % 8 == 7) begin
                rx.push_back(sh);
            end
        end
        // Mode 0,0 returns low before release, mode 1,1 stays high
        sck = cpol;
        #HALF_NS;
        selectN = 1'b1;
        sdi     = ~sdi; // Released line must not keep a stale bit
        #(5 * HALF_NS);
    endtask
endmodule
